// *** design/sies_defs.svh ***
// register offsets, field positions, reset values and widths of the serial irq/status bank
`ifndef SIES_DEFS_SVH
`define SIES_DEFS_SVH

`define SIES_ADDR_W        12
`define SIES_OFF_IER       12'h169
`define SIES_OFF_STATUS    12'h16a
`define SIES_OFF_TXDATA    12'h16b
`define SIES_OFF_RXDATA    12'h16c
`define SIES_OFF_CTRL      12'h16d

`define SIES_RST_IER       8'h00
`define SIES_RST_STATUS    8'h00
`define SIES_RST_CTRL      8'h00

// enable register fields
`define SIES_IE_ACKTX      0
`define SIES_IE_ACKRX      1
`define SIES_IE_ACKHALT    2
`define SIES_IE_STOP_RE    3
`define SIES_IE_NACK_TE    4
`define SIES_IE_RXFULL     5
`define SIES_IE_TXEND      6
`define SIES_IE_TXEMPTY    7

// status register fields
`define SIES_ST_CONFLICT   0
`define SIES_ST_SLAVEMATCH 1
`define SIES_ST_OVR_AL     2
`define SIES_ST_STOP       3
`define SIES_ST_NOACK      4
`define SIES_ST_RXFULL     5
`define SIES_ST_TXEND      6
`define SIES_ST_TXEMPTY    7

// control register fields
`define SIES_CT_TWOWIRE    0
`define SIES_CT_FOURWIRE   1
`define SIES_CT_CONTROLLER 2

`define SIES_WORD_BITS     4'h8

`endif

// *** design/sies_pkg.sv ***
// types shared by the serial irq/status bank
`include "sies_defs.svh"

package sies_pkg;

   typedef logic [`SIES_ADDR_W-1:0] sies_addr_t;
   typedef logic [7:0]              sies_byte_t;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_ACK   = 2'b10,
      ST_HALT  = 2'b11
   } sies_state_t;

endpackage

// *** design/sies_pin_if.sv ***
// carrier between the pin synchroniser and the bank
`timescale 1ns/100ps
`default_nettype none

interface sies_pin_if;
   logic [2:0] raw;
   logic [2:0] synced;

   modport sync
   (
      input  raw,
      output synced
   );

   modport user
   (
      output raw,
      input  synced
   );
endinterface

`default_nettype wire

// *** design/sies_sync.sv ***
// two-flop synchroniser for the serial pins
`timescale 1ns/100ps
`default_nettype none

module sies_sync
(
   input  wire logic clk,
   input  wire logic rst,
   sies_pin_if.sync  pins
);

   logic [2:0] meta_q;
   logic [2:0] sync_q;

   // first stage feeds only the second; bits are idle-high pins
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
      end
      else
      begin
         meta_q <= pins.raw;
         sync_q <= meta_q;
      end
   end

   assign pins.synced = sync_q;

endmodule

`default_nettype wire

// *** design/sies_top.sv ***
// serial unit interrupt-enable and status bank with a small shifter
`timescale 1ns/100ps
`default_nettype none
`include "sies_defs.svh"

// Operation
// R01: receive ack bit driven from ack_tx_select
// R02: returned ack captured into ack_rx_value
// R03: ack halt select stops on ack one
// R04: bit 3 gates stop-detect interrupt
// R05: software enables stop irq with flag clear
// R06: bit 4 gates noack and arbitration-lost
// R07: two-wire noack enable ignores overrun
// R08: bit 5 gates receive-full and overrun
// R09: overrun interrupt only in synchronous mode
// R10: bit 6 gates transmit-end interrupt
// R11: bit 7 gates transmit-empty interrupt
// R12: master start with select low: conflict
// R13: slave select rising mid-transfer: conflict
// R14: word done while receive full: overrun
// R15: overrun blocks receive, master also transmit
// R16: receive-full set on data, cleared by read
// R17: transmit-end loads transmit-empty at end
// R18: transmit-empty set on word load
// R19: transmit-data write clears end and empty
// R20: transmit enable rising sets transmit-empty
// R21: flags clear by zero after read one
// R22: software spaces status accesses one slot
// R23: interrupt line follows enabled active events
module sies_top
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire sies_pkg::sies_addr_t regAddr,
   input  wire sies_pkg::sies_byte_t regWdata,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   output logic      [7:0]         regRdata,
   input  wire logic               serClkPin,
   input  wire logic               serDataIn,
   output logic                    serDataOut,
   output logic                    serDataOe,
   input  wire logic               chipSelectPin,
   output logic                    irqReq
);
   import sies_pkg::*;

   sies_pin_if pins ();

   logic [7:0]  ier_q;
   logic [7:0]  flags_q;
   logic [7:0]  flags_d;
   logic [7:0]  armed_q;
   logic [7:0]  ctrl_q;
   logic [7:0]  txData_q;
   logic [7:0]  rxData_q;
   logic [7:0]  shift_q;
   logic [7:0]  shift_d;
   logic [3:0]  bitCnt_q;
   logic [3:0]  bitCnt_d;
   sies_state_t state_q;
   sies_state_t state_d;
   logic        txPending_q;
   logic        txActive_q;
   logic        txActive_d;
   logic        ackRx_q;
   logic        ackRx_d;
   logic        outBit_q;
   logic        outBit_d;
   logic        clkPrev_q;
   logic        dataPrev_q;
   logic        csPrev_q;
   logic [7:0]  statusView;
   logic [7:0]  flagSet;
   logic [7:0]  flagClr;
   logic        twoWire;
   logic        fourWire;
   logic        controller;
   logic        clkS;
   logic        dataS;
   logic        csS;
   logic        clkRise;
   logic        clkFall;
   logic        dataRise;
   logic        dataFall;
   logic        csRise;
   logic        wrIer;
   logic        wrStatus;
   logic        wrTx;
   logic        wrCtrl;
   logic        rdStatus;
   logic        rdRx;
   logic        rxAllowed;
   logic        txAllowed;
   logic        evLoad;
   logic        evEnd;
   logic        evRxDone;
   logic        evConflict;
   logic        evStop;
   logic        evNack;
   logic        evArbLost;
   logic        evTxEnRise;

   // pins cross into the clock domain before anything looks at them
   assign pins.raw = {chipSelectPin, serDataIn, serClkPin};

   sies_sync u_sync
   (
      .clk  (clk),
      .rst  (rst),
      .pins (pins)
   );

   assign clkS  = pins.synced[0];
   assign dataS = pins.synced[1];
   assign csS   = pins.synced[2];

   // edge detection on the synchronised levels
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         clkPrev_q  <= 1'b1;
         dataPrev_q <= 1'b1;
         csPrev_q   <= 1'b1;
      end
      else
      begin
         clkPrev_q  <= clkS;
         dataPrev_q <= dataS;
         csPrev_q   <= csS;
      end
   end

   assign clkRise  = clkS & ~clkPrev_q;
   assign clkFall  = ~clkS & clkPrev_q;
   assign dataRise = dataS & ~dataPrev_q;
   assign dataFall = ~dataS & dataPrev_q;
   assign csRise   = csS & ~csPrev_q;

   assign twoWire    = ctrl_q[`SIES_CT_TWOWIRE];
   assign fourWire   = ctrl_q[`SIES_CT_FOURWIRE] & ~twoWire;
   assign controller = ctrl_q[`SIES_CT_CONTROLLER];

   // address decode; unmapped addresses read zero and ignore writes
   assign wrIer    = regWrite & (regAddr == `SIES_OFF_IER);
   assign wrStatus = regWrite & (regAddr == `SIES_OFF_STATUS);
   assign wrTx     = regWrite & (regAddr == `SIES_OFF_TXDATA);
   assign wrCtrl   = regWrite & (regAddr == `SIES_OFF_CTRL);
   assign rdStatus = regRead & (regAddr == `SIES_OFF_STATUS);
   assign rdRx     = regRead & (regAddr == `SIES_OFF_RXDATA);

   // overrun freezes the receiver, and a master's transmitter too
   assign rxAllowed = ~flags_q[`SIES_ST_OVR_AL] &
                      (twoWire | ier_q[`SIES_IE_STOP_RE]); // see R15
   assign txAllowed = ~(flags_q[`SIES_ST_OVR_AL] & controller & ~twoWire) &
                      (twoWire | ier_q[`SIES_IE_NACK_TE]); // see R15

   // transmit enable going high in synchronous mode
   assign evTxEnRise = wrIer & ~twoWire & regWdata[`SIES_IE_NACK_TE] &
                       ~ier_q[`SIES_IE_NACK_TE];

   // shifter sequencing: sample on rising link edge, drive on falling
   always_comb
   begin
      state_d    = state_q;
      shift_d    = shift_q;
      bitCnt_d   = bitCnt_q;
      txActive_d = txActive_q;
      ackRx_d    = ackRx_q;
      outBit_d   = outBit_q;
      evLoad     = 1'b0;
      evEnd      = 1'b0;
      evRxDone   = 1'b0;
      evConflict = 1'b0;
      evStop     = 1'b0;
      evNack     = 1'b0;
      evArbLost  = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (txPending_q && !txActive_q && txAllowed)
            begin
               shift_d    = txData_q;
               txActive_d = 1'b1;
               outBit_d   = txData_q[7];
               evLoad     = 1'b1; // see R18
            end
            else if (clkRise && (txActive_q || rxAllowed))
            begin
               if (fourWire && controller && !csS)
                  evConflict = 1'b1; // see R12
               shift_d  = {shift_q[6:0], dataS};
               bitCnt_d = 4'h1;
               state_d  = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (clkFall && txActive_q)
               outBit_d = shift_q[7];
            if (clkRise)
            begin
               if (twoWire && txActive_q && outBit_q && !dataS)
               begin
                  evArbLost  = 1'b1;
                  txActive_d = 1'b0;
                  state_d    = ST_IDLE;
               end
               else
               begin
                  shift_d  = {shift_q[6:0], dataS};
                  bitCnt_d = bitCnt_q + 4'h1;
                  if (bitCnt_q == `SIES_WORD_BITS - 4'h1)
                  begin
                     // outside two-wire a word is kept only with reception enabled
                     evRxDone = twoWire ? ~txActive_q : ier_q[`SIES_IE_STOP_RE];
                     if (twoWire)
                     begin
                        state_d = ST_ACK;
                        // a receiver stays off the line until the ack slot opens
                        if (!txActive_q)
                           outBit_d = 1'b1;
                     end
                     else
                     begin
                        evEnd      = txActive_q; // see R17
                        txActive_d = 1'b0;
                        state_d    = ST_IDLE;
                     end
                  end
               end
            end
         end
         ST_ACK:
         begin
            if (clkFall)
               outBit_d = txActive_q ? 1'b1 : ier_q[`SIES_IE_ACKTX]; // see R01
            if (clkRise)
            begin
               evEnd      = txActive_q;
               txActive_d = 1'b0;
               state_d    = ST_IDLE;
               if (txActive_q)
               begin
                  ackRx_d = dataS; // see R02
                  if (dataS)
                     evNack = 1'b1;
                  if (dataS && ier_q[`SIES_IE_ACKHALT])
                     state_d = ST_HALT; // see R03
               end
            end
         end
         ST_HALT:
         begin
            if (!flags_q[`SIES_ST_NOACK])
               state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
      // two-wire start or stop on the data line while clock is high
      if (twoWire && clkS && (dataRise || dataFall) && state_q != ST_HALT)
      begin
         evStop     = dataRise;
         state_d    = ST_IDLE;
         txActive_d = txActive_q & (state_q == ST_IDLE);
         bitCnt_d   = 4'h0;
      end
      if (fourWire && !controller && csRise &&
          (state_q == ST_SHIFT || state_q == ST_ACK))
         evConflict = 1'b1; // see R13
   end

   // shifter state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q    <= ST_IDLE;
         shift_q    <= 8'h00;
         bitCnt_q   <= 4'h0;
         txActive_q <= 1'b0;
         ackRx_q    <= 1'b0;
         outBit_q   <= 1'b1;
      end
      else
      begin
         state_q    <= state_d;
         shift_q    <= shift_d;
         bitCnt_q   <= bitCnt_d;
         txActive_q <= txActive_d;
         ackRx_q    <= ackRx_d;
         outBit_q   <= outBit_d;
      end
   end

   // pending transmit word: a write arms it, the load takes it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         txData_q    <= 8'h00;
         txPending_q <= 1'b0;
      end
      else if (wrTx)
      begin
         txData_q    <= regWdata;
         txPending_q <= 1'b1;
      end
      else if (evLoad)
         txPending_q <= 1'b0;
   end

   // received word is kept only when the buffer is free
   always_ff @(posedge clk)
   begin
      if (rst)
         rxData_q <= 8'h00;
      else if (evRxDone && !flags_q[`SIES_ST_RXFULL] && !flags_q[`SIES_ST_OVR_AL])
         rxData_q <= shift_d;
   end

   // writable enable bits; the received ack bit is read-only
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ier_q  <= `SIES_RST_IER;
         ctrl_q <= `SIES_RST_CTRL;
      end
      else
      begin
         if (wrIer)
            ier_q <= regWdata & ~(8'h01 << `SIES_IE_ACKRX);
         if (wrCtrl)
            ctrl_q <= regWdata & 8'h07;
      end
   end

   // status flag events
   always_comb
   begin
      flagSet = 8'h00;
      flagClr = 8'h00;
      flagSet[`SIES_ST_CONFLICT] = evConflict;
      flagSet[`SIES_ST_OVR_AL]   = (evRxDone & flags_q[`SIES_ST_RXFULL] & ~twoWire)
                                   | evArbLost; // see R14
      flagSet[`SIES_ST_STOP]     = evStop;
      flagSet[`SIES_ST_NOACK]    = evNack;
      flagSet[`SIES_ST_RXFULL]   = evRxDone & ~flags_q[`SIES_ST_RXFULL] &
                                   ~flags_q[`SIES_ST_OVR_AL]; // see R16
      flagSet[`SIES_ST_TXEMPTY]  = evLoad | evTxEnRise; // see R20
      // zero written to a flag seen as one; ones are ignored
      if (wrStatus)
         flagClr = ~regWdata & armed_q; // see R21
      // outside two-wire the receive-full flag ignores written zeros
      if (!twoWire)
         flagClr[`SIES_ST_RXFULL] = 1'b0; // see R16
      if (rdRx)
         flagClr[`SIES_ST_RXFULL] = 1'b1; // see R16
      if (wrTx)
      begin
         flagClr[`SIES_ST_TXEND]   = 1'b1; // see R19
         flagClr[`SIES_ST_TXEMPTY] = 1'b1; // see R19
      end
      // set beats clear so an event in the clearing cycle survives
      flags_d = (flags_q & ~flagClr) | flagSet;
      // the end flag copies the empty flag as the last bit leaves
      if (evEnd)
         flags_d[`SIES_ST_TXEND] = flags_q[`SIES_ST_TXEMPTY] | flagSet[`SIES_ST_TXEMPTY];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         flags_q <= `SIES_RST_STATUS;
      else
         flags_q <= flags_d;
   end

   // read-as-one arming for the write-zero clear
   always_ff @(posedge clk)
   begin
      if (rst)
         armed_q <= 8'h00;
      else if (wrStatus)
         armed_q <= 8'h00;
      else if (rdStatus)
         armed_q <= armed_q | statusView;
   end

   // status as software sees it, by mode
   always_comb
   begin
      statusView = flags_q;
      statusView[`SIES_ST_SLAVEMATCH] = 1'b0;
      if (!twoWire)
      begin
         statusView[`SIES_ST_STOP]  = 1'b0;
         statusView[`SIES_ST_NOACK] = 1'b0;
      end
      else
         statusView[`SIES_ST_CONFLICT] = 1'b0;
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk)
   begin
      if (rst)
         regRdata <= 8'h00;
      else if (!regRead)
         regRdata <= 8'h00;
      else
      begin
         case (regAddr)
            `SIES_OFF_IER:    regRdata <= ier_q | ({7'h00, ackRx_q} << `SIES_IE_ACKRX);
            `SIES_OFF_STATUS: regRdata <= statusView;
            `SIES_OFF_TXDATA: regRdata <= txData_q;
            `SIES_OFF_RXDATA: regRdata <= rxData_q;
            `SIES_OFF_CTRL:   regRdata <= ctrl_q;
            default:          regRdata <= 8'h00;
         endcase
      end
   end

   // data pin: open drain low in two-wire, push while sending otherwise
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         serDataOut <= 1'b0;
         serDataOe  <= 1'b0;
      end
      else if (twoWire)
      begin
         serDataOut <= 1'b0;
         serDataOe  <= ~outBit_d & (txActive_d | state_d == ST_ACK);
      end
      else
      begin
         serDataOut <= outBit_d;
         serDataOe  <= txActive_d;
      end
   end

   // interrupt line: enabled active events, gating differs by mode
   always_ff @(posedge clk)
   begin
      if (rst)
         irqReq <= 1'b0;
      else if (twoWire)
         irqReq <= (flags_q[`SIES_ST_TXEMPTY] & ier_q[`SIES_IE_TXEMPTY])   // see R11
                 | (flags_q[`SIES_ST_TXEND] & ier_q[`SIES_IE_TXEND])       // see R10
                 | (flags_q[`SIES_ST_RXFULL] & ier_q[`SIES_IE_RXFULL])     // see R08
                 | (flags_q[`SIES_ST_STOP] & ier_q[`SIES_IE_STOP_RE])      // see R04
                 | ((flags_q[`SIES_ST_NOACK] | flags_q[`SIES_ST_OVR_AL])
                    & ier_q[`SIES_IE_NACK_TE]);                             // see R06
      else
         irqReq <= (flags_q[`SIES_ST_TXEMPTY] & ier_q[`SIES_IE_TXEMPTY])   // see R11
                 | (flags_q[`SIES_ST_TXEND] & ier_q[`SIES_IE_TXEND])       // see R10
                 | ((flags_q[`SIES_ST_RXFULL] | flags_q[`SIES_ST_OVR_AL])
                    & ier_q[`SIES_IE_RXFULL])                               // see R09
                 | (flags_q[`SIES_ST_CONFLICT] & ier_q[`SIES_IE_ACKTX]);   // see R23
   end
   // note: overrun in two-wire does not exist; bit 2 there is arbitration lost  see R07

endmodule

`default_nettype wire

// *** sim/sies_top_sva.sv ***
// port-level assertions for the serial irq/status bank
`timescale 1ns/100ps
`default_nettype none
`include "sies_defs.svh"

module sies_chk
(
   input wire logic                 clk,
   input wire logic                 rst,
   input wire sies_pkg::sies_addr_t regAddr,
   input wire sies_pkg::sies_byte_t regWdata,
   input wire logic                 regWrite,
   input wire logic                 regRead,
   input wire logic [7:0]           regRdata,
   input wire logic                 serClkPin,
   input wire logic                 serDataIn,
   input wire logic                 serDataOut,
   input wire logic                 serDataOe,
   input wire logic                 chipSelectPin,
   input wire logic                 irqReq
);
   import sies_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic [7:0] mode_q;
   logic [7:0] ie_q;
   logic [7:0] wd_q;

   // mirror of software writes; the pins alone do not show the mode
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_q <= 8'h00;
         ie_q   <= 8'h00;
         wd_q   <= 8'h00;
      end
      else if (regWrite)
      begin
         wd_q <= regWdata;
         if (regAddr == `SIES_OFF_CTRL)
            mode_q <= regWdata;
         if (regAddr == `SIES_OFF_IER)
            ie_q <= regWdata;
      end
   end

   sequence ieThenIe;
      regWrite && regAddr == `SIES_OFF_IER && !mode_q[1] ##2 regRead && regAddr == `SIES_OFF_IER;
   endsequence
   sequence txThenSt;
      regWrite && regAddr == `SIES_OFF_TXDATA ##2 regRead && regAddr == `SIES_OFF_STATUS;
   endsequence
   sequence rxThenSt;
      regRead && regAddr == `SIES_OFF_RXDATA ##2 regRead && regAddr == `SIES_OFF_STATUS;
   endsequence
   sequence txOnThenSt;
      regWrite && regAddr == `SIES_OFF_IER && regWdata[4] && !ie_q[4] && !mode_q[0]
         ##2 regRead && regAddr == `SIES_OFF_STATUS;
   endsequence

   a_ie_readback: assert property (ieThenIe |=> regRdata[7:2] == wd_q[7:2] && regRdata[0] == wd_q[0])
      else $error("enable register readback differs from write");
   a_irq_off: assert property (ie_q == 8'h00 && $past(ie_q) == 8'h00 |-> !irqReq)
      else $error("interrupt with every enable off");
   a_irq_drop: assert property (regWrite && regAddr == `SIES_OFF_IER && regWdata == 8'h00 |-> ##[1:2] !irqReq)
      else $error("interrupt stayed after enables cleared");
   a_twowire_out: assert property (mode_q[0] && $past(mode_q[0]) |-> !serDataOut)
      else $error("two-wire data output not held low");
   a_rx_clear: assert property (rxThenSt |=> !regRdata[5])
      else $error("receive full survived a data read");
   a_txend_clear: assert property (txThenSt |=> !regRdata[6])
      else $error("transmit end survived a data write");
   a_txen_empty: assert property (txOnThenSt |=> regRdata[7])
      else $error("transmit enable did not set empty flag");
   a_reset_quiet: assert property ($fell(rst) |-> !irqReq && !serDataOe && regRdata == 8'h00)
      else $error("outputs active right after reset");
endmodule

bind sies_top sies_chk chk_u
(
   .clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
   .serClkPin, .serDataIn, .serDataOut, .serDataOe, .chipSelectPin, .irqReq
);

`default_nettype wire

// *** sim/sies_peer.sv ***
// behavioural serial peer: link clock and data toward the bank
`timescale 1ns/100ps
`default_nettype none

module sies_peer
(
   output logic linkClk,
   output logic linkData
);
   logic pullUp; // two-wire line floats high when released

   // clock idles high outside words
   initial
   begin
      linkClk = 1'b1;
      linkData = 1'b0;
      pullUp = 1'b0;
   end

   // ninth clock of a two-wire word; peer shows its ack level
   task automatic ackSlot(input logic a);
      linkClk = 1'b0;
      linkData = a;
      #24;
      linkClk = 1'b1;
      #24;
   endtask

   // one word msb first, 48 ns a bit, data moves on the falling edge
   task automatic frame(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         linkClk = 1'b0;
         linkData = b[i];
         #24;
         linkClk = 1'b1;
         #24;
      end
      // released line: pulled high on two-wire, else the inverse of the last bit
      linkData = pullUp ? 1'b1 : ~linkData;
   endtask
endmodule

`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the serial irq/status bank
`timescale 1ns/100ps
`default_nettype none
`include "sies_defs.svh"

module testbench;
   import sies_pkg::*;
   logic        clk, rst, regWrite, regRead, rdDly;
   logic        serClkPin, serDataIn, serDataOut, serDataOe, chipSelectPin, irqReq;
   sies_addr_t  regAddr;
   sies_byte_t  regWdata;
   logic [7:0]  regRdata, b1, b2;
   logic [15:0] note;
   logic [15:0] expQ[$];
   int          badCount, comparisons;

   sies_top dut_u
   (
      .clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .serClkPin, .serDataIn, .serDataOut, .serDataOe, .chipSelectPin, .irqReq
   );
   sies_peer peer_u (.linkClk(serClkPin), .linkData(serDataIn));

   always #2 clk = ~clk;

   task automatic compare(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
      comparisons++;
      if ((got & msk) !== (exp & msk))
      begin
         badCount++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // every access waits an edge first, so accesses never abut
   task automatic wr(input sies_addr_t a, input sies_byte_t d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input sies_addr_t a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      expQ.push_back({m, e});
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic irqIs(input logic e);
      idle(3);
      @(negedge clk);
      compare({7'h00, irqReq}, {7'h00, e}, 8'h01);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // read data stands one cycle after the strobe
   always @(posedge clk)
      rdDly <= regRead;
   always @(negedge clk)
   begin
      if (rdDly && expQ.size() == 0)
      begin
         badCount++;
         $display("[FAIL] %0t read data with no expectation", $time);
      end
      else if (rdDly)
      begin
         note = expQ.pop_front();
         compare(regRdata, note[7:0], note[15:8]);
      end
   end

   // hang guard
   initial
   begin
      #40000;
      badCount++;
      $display("[FAIL] %0t run timed out", $time);
      conclude();
   end

   initial
   begin
      {clk, regWrite, regRead, rdDly, badCount, comparisons} = '0;
      {rst, chipSelectPin} = 2'b11;
      regAddr = '0;
      regWdata = '0;
      b1 = 8'($urandom(49));
      idle(2);
      rst <= 1'b0;
      rd(`SIES_OFF_IER, 8'h00, 8'hff);
      rd(`SIES_OFF_STATUS, 8'h00, 8'hff);
      rd(12'h170, 8'h00, 8'hff);
      $display("test reset done");
      b1 = 8'($urandom);
      wr(`SIES_OFF_IER, b1);
      rd(`SIES_OFF_IER, b1 & 8'hfd, 8'hff);
      wr(`SIES_OFF_IER, 8'h00);
      wr(`SIES_OFF_IER, 8'h10);
      rd(`SIES_OFF_STATUS, 8'h80, 8'hff);
      irqIs(1'b0);
      wr(`SIES_OFF_IER, 8'h90);
      irqIs(1'b1);
      $display("test enable done");
      wr(`SIES_OFF_TXDATA, 8'h5a);
      rd(`SIES_OFF_STATUS, 8'h00, 8'h40);
      rd(`SIES_OFF_STATUS, 8'h80, 8'hff);
      peer_u.frame(8'($urandom));
      idle(6);
      rd(`SIES_OFF_STATUS, 8'hc0, 8'hff);
      wr(`SIES_OFF_IER, 8'h50);
      irqIs(1'b1);
      wr(`SIES_OFF_IER, 8'h10);
      irqIs(1'b0);
      wr(`SIES_OFF_STATUS, 8'hff);
      rd(`SIES_OFF_STATUS, 8'hc0, 8'hff);
      wr(`SIES_OFF_STATUS, 8'h00);
      rd(`SIES_OFF_STATUS, 8'h00, 8'hff);
      $display("test transmit done");
      wr(`SIES_OFF_IER, 8'h28);
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      peer_u.frame(b1);
      idle(6);
      irqIs(1'b1);
      rd(`SIES_OFF_STATUS, 8'h20, 8'hff);
      peer_u.frame(b2);
      idle(6);
      rd(`SIES_OFF_STATUS, 8'h24, 8'hff);
      rd(`SIES_OFF_RXDATA, b1, 8'hff);
      rd(`SIES_OFF_STATUS, 8'h04, 8'hff);
      peer_u.frame(b2);
      idle(6);
      rd(`SIES_OFF_STATUS, 8'h04, 8'hff);
      wr(`SIES_OFF_STATUS, 8'hfb);
      rd(`SIES_OFF_STATUS, 8'h00, 8'hff);
      peer_u.frame(b2);
      idle(6);
      rd(`SIES_OFF_STATUS, 8'h20, 8'hff);
      wr(`SIES_OFF_STATUS, 8'h00);
      rd(`SIES_OFF_STATUS, 8'h20, 8'hff);
      rd(`SIES_OFF_RXDATA, b2, 8'hff);
      $display("test receive done");
      wr(`SIES_OFF_IER, 8'h00);
      wr(`SIES_OFF_CTRL, 8'h06);
      chipSelectPin <= 1'b0;
      wr(`SIES_OFF_IER, 8'h11);
      wr(`SIES_OFF_TXDATA, 8'hc3);
      peer_u.frame(8'($urandom));
      idle(6);
      rd(`SIES_OFF_STATUS, 8'h01, 8'h01);
      irqIs(1'b1);
      wr(`SIES_OFF_STATUS, 8'hfe);
      wr(`SIES_OFF_IER, 8'h00);
      wr(`SIES_OFF_CTRL, 8'h02);
      wr(`SIES_OFF_IER, 8'h08);
      fork
         peer_u.frame(8'h3c);
         begin
            repeat (49) @(posedge clk);
            chipSelectPin <= 1'b1; // rises mid-word
         end
      join
      idle(6);
      rd(`SIES_OFF_STATUS, 8'h01, 8'h01);
      rd(`SIES_OFF_RXDATA, 8'h3c, 8'hff);
      $display("test conflict done");
      wr(`SIES_OFF_CTRL, 8'h01);
      wr(`SIES_OFF_IER, 8'h00);
      peer_u.pullUp = 1'b1;
      peer_u.frame(8'h81);
      fork
         peer_u.ackSlot(1'b1);
         begin
            idle(5);
            @(negedge clk);
            compare({7'h00, serDataOe}, 8'h01, 8'h01);
         end
      join
      rd(`SIES_OFF_RXDATA, 8'h81, 8'hff);
      wr(`SIES_OFF_IER, 8'h04);
      wr(`SIES_OFF_TXDATA, 8'ha5);
      peer_u.frame(8'ha5);
      peer_u.ackSlot(1'b1);
      rd(`SIES_OFF_IER, 8'h06, 8'hff);
      peer_u.frame(8'h81);
      rd(`SIES_OFF_STATUS, 8'h10, 8'h30);
      wr(`SIES_OFF_IER, 8'h14);
      irqIs(1'b1);
      wr(`SIES_OFF_STATUS, 8'hef);
      irqIs(1'b0);
      wr(`SIES_OFF_IER, 8'h08);
      peer_u.frame(8'h00);
      idle(2);
      irqIs(1'b1);
      wr(`SIES_OFF_IER, 8'h00);
      irqIs(1'b0);
      for (int i = 0; i < 8 && expQ.size() > 0; i++)
         @(posedge clk);
      if (expQ.size() > 0)
      begin
         badCount++;
         $display("[FAIL] %0t reads left unchecked", $time);
      end
      $display("test two-wire done");
      conclude();
   end
endmodule

`default_nettype wire
